// File: include/cts_cfg.svh
// Register map, field positions, reset values and sizes of the scheduler.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH
`define CTS_AW 12
`define CTS_OFF_MODE 12'h000
`define CTS_OFF_SETTINGS 12'h004
`define CTS_OFF_PRIORITY 12'h008
`define CTS_OFF_STATUS 12'h070
`define CTS_OFF_COMMAND 12'h074
`define CTS_OFF_RETRY 12'h078
`define CTS_SLOT_FIRST 4'h1
`define CTS_MODE_TTM 0
`define CTS_MODE_FDE 1
`define CTS_SET_RLE 0
`define CTS_SET_RTH_LO 1
`define CTS_SET_RTH_HI 4
`define CTS_SET_FOB 5
`define CTS_SET_ENA 6
`define CTS_MODE_RST 32'h0000_0000
`define CTS_SET_RST 32'h0000_0020
`define CTS_PRIO_RST 32'h0000_0000
`define CTS_CMD_EMPTY 0
`define CTS_CMD_READY 1
`define CTS_CMD_ABORT 2
`define CTS_CMD_SEL 8
`define CTS_FMT_DLC_HI 3
`define CTS_FMT_RTR 5
`define CTS_FMT_FDF 7
`define CTS_W_FMT 5'h00
`define CTS_W_TSL 5'h02
`define CTS_W_TSH 5'h03
`define CTS_W_CLASSIC_LAST 5'h05
`define CTS_WORDS 20
`define CTS_SLOTS 4
`define CTS_PRIO_W 3
`define CTS_RESP_OKAY 2'b00
`define CTS_RESP_SLVERR 2'b10
`endif

// File: include/cts_pkg.sv
// Types shared by the transmit scheduler files.
package cts_pkg;
	typedef enum logic [6:0] {
		CTS_S_EMPTY = 7'b0000001,
		CTS_S_READY = 7'b0000010,
		CTS_S_TXING = 7'b0000100,
		CTS_S_ABTIP = 7'b0001000,
		CTS_S_OK = 7'b0010000,
		CTS_S_FAILED = 7'b0100000,
		CTS_S_ABORTED = 7'b1000000
	} cts_slot_t;
	typedef enum logic [1:0] {
		CTS_E_IDLE = 2'b01,
		CTS_E_TX = 2'b10
	} cts_eng_t;
endpackage

// File: design/cts_slot_mem.sv
// Frame store for all transmit slots with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module cts_slot_mem #(
	parameter int N = 4,
	parameter int WORDS = 20
) (
	// Clock.
	input wire logic sys_clk_i,
	// Write port.
	input wire logic we_i,
	input wire logic [$clog2(N)-1:0] w_slot_i,
	input wire logic [4:0] w_word_i,
	input wire logic [31:0] w_data_i,
	input wire logic [3:0] w_strb_i,
	// Read port.
	input wire logic [$clog2(N)-1:0] r_slot_i,
	input wire logic [4:0] r_word_i,
	input wire logic r_zero_i,
	output logic [31:0] r_data_o
);
	// Contents are never cleared, so software must fill a slot first.
	logic [31:0] mem [N*WORDS];
	always_ff @(posedge sys_clk_i) begin
		for (int b = 0; b < 4; b++) begin
			if (we_i && w_strb_i[b] && int'(w_word_i) < WORDS) begin
				mem[int'(w_slot_i)*WORDS+int'(w_word_i)][b*8+:8] <=
					w_data_i[b*8+:8];
			end
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (r_zero_i || int'(r_word_i) >= WORDS) begin
			r_data_o <= 32'h0000_0000;
		end else begin
			r_data_o <= mem[int'(r_slot_i)*WORDS+int'(r_word_i)];
		end
	end
endmodule // cts_slot_mem
`default_nettype wire

// File: design/cts_slot_pick.sv
// Picks the ready slot of highest priority, lower index on a tie.
`timescale 1ns/10ps
`default_nettype none
module cts_slot_pick #(
	parameter int N = 4,
	parameter int PW = 3
) (
	// Candidates.
	input wire logic [N-1:0] ready_i,
	input wire logic [N*PW-1:0] prio_i,
	// Choice.
	output logic found_o,
	output logic [$clog2(N)-1:0] idx_o
);
	always_comb begin
		logic [PW-1:0] best;
		best = '0;
		found_o = 1'b0;
		idx_o = '0;
		// Walking downward with >= lets the lower index win a tie.
		for (int i = N - 1; i >= 0; i--) begin
			if (ready_i[i] && (!found_o || prio_i[i*PW+:PW] >= best)) begin
				found_o = 1'b1;
				best = prio_i[i*PW+:PW];
				idx_o = ($clog2(N))'(i);
			end
		end
	end
endmodule // cts_slot_pick
`default_nettype wire

// File: design/cts_tx_sched.sv
// Transmit slot scheduler with AXI4-Lite register access.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
// Summary of operation
// - In time-trigger mode a slot starts only once time base reaches its time.
// - The time base is an up-counting unsigned counter.
// - After the time, still wait for idle; a foreign frame makes us receiver.
// - Priority is judged before time; the higher priority slot wins.
// - While waiting, re-pick on priority change; once started, never swap.
// - FD requested with FD disabled sends classical, dropping bytes past 8.
// - Remote flag with FD format is ignored; a data frame goes out, FD only while FD is enabled.
// - With the limit off, retry until success, abort, or bus-off with fail-on-bus-off set.
// - Limit on and threshold zero gives exactly one attempt.
// - Limit on and threshold 1 to 15 gives threshold plus one attempts.
// - When all allowed attempts fail, the slot becomes transmit-failed.
// - The attempt counter clears whenever the transmitting slot changes.
// - The attempt counter clears when the slot in use becomes aborted.
// - Software reads the count of retransmissions already spent in a retry register.
// - Abort on a ready slot moves it to aborted at once.
// - Abort while sending gives abort-in-progress, then aborted, ok or failed.
// - Bus-off with fail-on-bus-off set fails every ready or busy slot.
// - Without fail-on-bus-off, bus-off acts as an error frame on the slot.
// - Ready during bus-off with fail-on-bus-off set aborts; software waits for error-active.
// - Overload frames are sent only in reaction to an overload condition.
// - Larger priority value wins; equal priority goes to the lower index.
// - After an error frame the slot returns ready for retry.
module cts_tx_sched #(
	parameter int N = `CTS_SLOTS,
	parameter int PW = `CTS_PRIO_W
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// AXI4-Lite write channels.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`CTS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read channels.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`CTS_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Protocol engine status.
	input wire logic [63:0] time_base_i,
	input wire logic bus_idle_i,
	input wire logic rx_sof_i,
	input wire logic tx_ok_i,
	input wire logic tx_err_i,
	input wire logic bus_off_i,
	input wire logic overload_cond_i,
	// Frame handed to the protocol engine.
	output logic tx_start_o,
	output logic [$clog2(N)-1:0] tx_slot_o,
	output logic tx_fd_o,
	output logic tx_rtr_o,
	output logic [3:0] tx_dlc_o,
	input wire logic [4:0] tx_rd_word_i,
	output logic [31:0] tx_word_o,
	output logic overload_o
);
	localparam int SW = $clog2(N);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8+:8] = d[b*8+:8];
			end
		end
		return r;
	endfunction

	// A slot may be rewritten only while no transmission owns it.
	function automatic logic open_slot(input cts_pkg::cts_slot_t s);
		return s == cts_pkg::CTS_S_EMPTY || s == cts_pkg::CTS_S_OK ||
			s == cts_pkg::CTS_S_FAILED || s == cts_pkg::CTS_S_ABORTED;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic aw_h;
	logic w_h;
	logic [`CTS_AW-1:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] s_q;
	logic wr_do;
	logic [31:0] mode_r;
	logic [31:0] set_r;
	logic [31:0] prio_r;
	cts_pkg::cts_slot_t st [N];
	cts_pkg::cts_eng_t eng;
	logic [SW-1:0] cur;
	logic [SW-1:0] last;
	logic last_vld;
	logic [3:0] rcnt;
	logic [31:0] tsl [N];
	logic [31:0] tsh [N];
	logic [31:0] fmt [N];
	logic rx_busy;
	logic boff_q;

	assign wr_do = aw_h && w_h && !s_axi_bvalid;
	wire [3:0] w_reg = aw_q[11:8];
	wire w_slot_hit = w_reg >= `CTS_SLOT_FIRST &&
		int'(w_reg) < int'(`CTS_SLOT_FIRST) + N;
	wire [SW-1:0] w_slot = SW'(w_reg - `CTS_SLOT_FIRST);
	wire [4:0] w_word = aw_q[6:2];
	wire w_mem = wr_do && w_slot_hit && open_slot(st[w_slot]);
	wire cmd_we = wr_do && aw_q == `CTS_OFF_COMMAND;
	wire [N-1:0] cmd_sel = cmd_we ? w_q[`CTS_CMD_SEL+:N] : '0;
	wire ttm = mode_r[`CTS_MODE_TTM];
	wire fde = mode_r[`CTS_MODE_FDE];
	wire rle = set_r[`CTS_SET_RLE];
	wire [3:0] rth = set_r[`CTS_SET_RTH_HI:`CTS_SET_RTH_LO];
	wire fob = set_r[`CTS_SET_FOB];
	wire ena = set_r[`CTS_SET_ENA];
	wire boff_ev = bus_off_i && !boff_q;
	wire in_tx = eng == cts_pkg::CTS_E_TX;
	// Bus-off without the fail option counts as one more error frame.
	wire ev_err = in_tx && (tx_err_i || (boff_ev && !fob));
	wire ev_ok = in_tx && tx_ok_i && !ev_err;
	wire lim = rle && rcnt == rth;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_h <= 1'b0;
			s_axi_awready <= 1'b1;
			aw_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_h <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_q <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_h <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			w_h <= 1'b0;
			s_axi_wready <= 1'b1;
			w_q <= '0;
			s_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_h <= 1'b1;
			s_axi_wready <= 1'b0;
			w_q <= s_axi_wdata;
			s_q <= s_axi_wstrb;
		end else if (wr_do) begin
			w_h <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CTS_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_q == `CTS_OFF_MODE ||
				aw_q == `CTS_OFF_SETTINGS || aw_q == `CTS_OFF_PRIORITY ||
				aw_q == `CTS_OFF_COMMAND || w_slot_hit) ?
				`CTS_RESP_OKAY : `CTS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_r <= `CTS_MODE_RST;
			set_r <= `CTS_SET_RST;
			prio_r <= `CTS_PRIO_RST;
		end else if (wr_do) begin
			if (aw_q == `CTS_OFF_MODE) begin
				mode_r <= merge(mode_r, w_q, s_q);
			end
			if (aw_q == `CTS_OFF_SETTINGS) begin
				set_r <= merge(set_r, w_q, s_q);
			end
			if (aw_q == `CTS_OFF_PRIORITY) begin
				prio_r <= merge(prio_r, w_q, s_q);
			end
		end
	end

	// Format and time words are mirrored here so selection needs no read.
	always_ff @(posedge sys_clk_i) begin
		if (w_mem && w_word == `CTS_W_FMT) begin
			fmt[w_slot] <= merge(fmt[w_slot], w_q, s_q);
		end
		if (w_mem && w_word == `CTS_W_TSL) begin
			tsl[w_slot] <= merge(tsl[w_slot], w_q, s_q);
		end
		if (w_mem && w_word == `CTS_W_TSH) begin
			tsh[w_slot] <= merge(tsh[w_slot], w_q, s_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`CTS_OFF_MODE: rd_mux = mode_r;
			`CTS_OFF_SETTINGS: rd_mux = set_r;
			`CTS_OFF_PRIORITY: rd_mux = prio_r;
			`CTS_OFF_STATUS: begin
				for (int i = 0; i < N && i < 4; i++) begin
					rd_mux[i*8+:8] = {1'b0, st[i]};
				end
			end
			`CTS_OFF_COMMAND: rd_mux = '0;
			`CTS_OFF_RETRY: rd_mux = {28'h0000000, rcnt};
			default: rd_hit = s_axi_araddr[11:8] >= `CTS_SLOT_FIRST &&
				int'(s_axi_araddr[11:8]) < int'(`CTS_SLOT_FIRST) + N;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `CTS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? `CTS_RESP_OKAY : `CTS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [N-1:0] rdy_vec;
	logic pick_ok;
	logic [SW-1:0] pick;
	always_comb begin
		for (int i = 0; i < N; i++) begin
			rdy_vec[i] = st[i] == cts_pkg::CTS_S_READY;
		end
	end

	cts_slot_pick #(.N(N), .PW(PW)) u_pick (
		.ready_i(rdy_vec),
		.prio_i(prio_r[N*PW-1:0]),
		.found_o(pick_ok),
		.idx_o(pick)
	);

	// Only the current best slot is timed, so priority always comes first.
	wire reached = !ttm || time_base_i >= {tsh[pick], tsl[pick]};
	wire start_ok = !in_tx && ena && !bus_off_i && pick_ok && reached &&
		bus_idle_i && !rx_sof_i && !rx_busy;
	wire fd_eff = fmt[pick][`CTS_FMT_FDF] && fde;

	// A frame begun by another node keeps us receiving until idle.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_busy <= 1'b0;
			boff_q <= 1'b0;
		end else begin
			rx_busy <= rx_sof_i || (rx_busy && !bus_idle_i);
			boff_q <= bus_off_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			eng <= cts_pkg::CTS_E_IDLE;
			cur <= '0;
			tx_start_o <= 1'b0;
			tx_slot_o <= '0;
			tx_fd_o <= 1'b0;
			tx_rtr_o <= 1'b0;
			tx_dlc_o <= '0;
		end else begin
			tx_start_o <= 1'b0;
			case (eng)
				cts_pkg::CTS_E_IDLE: begin
					if (start_ok) begin
						eng <= cts_pkg::CTS_E_TX;
						cur <= pick;
						tx_start_o <= 1'b1;
						tx_slot_o <= pick;
						tx_fd_o <= fd_eff;
						tx_rtr_o <= fmt[pick][`CTS_FMT_RTR] &&
							!fmt[pick][`CTS_FMT_FDF];
						tx_dlc_o <= fmt[pick][`CTS_FMT_DLC_HI:0];
					end
				end
				cts_pkg::CTS_E_TX: begin
					// Started frames are never swapped for a better slot.
					if (ev_ok || ev_err || boff_ev) begin
						eng <= cts_pkg::CTS_E_IDLE;
					end
				end
				default: eng <= cts_pkg::CTS_E_IDLE;
			endcase
		end
	end

	// Attempt bookkeeping; rcnt counts retransmissions already spent.
	// An abort that meets the error edge counts as an abort, unless the retry limit fails the slot.
	wire abort_now = ev_err && (st[cur] == cts_pkg::CTS_S_ABTIP ||
		(cmd_sel[cur] && w_q[`CTS_CMD_ABORT]));
	wire cur_abort = abort_now ||
		(last_vld && cmd_sel[last] && w_q[`CTS_CMD_ABORT] &&
		st[last] == cts_pkg::CTS_S_READY);
	// A finished frame leaves no spent attempts behind for the next one.
	wire frame_done = ev_ok || (ev_err && lim) || (boff_ev && fob);
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rcnt <= '0;
			last <= '0;
			last_vld <= 1'b0;
		end else if (cur_abort) begin
			rcnt <= '0;
			last_vld <= 1'b0;
		end else if (frame_done) begin
			rcnt <= '0;
		end else if (start_ok) begin
			last <= pick;
			last_vld <= 1'b1;
			if (!last_vld || pick != last) begin
				rcnt <= '0;
			end
		end else if (ev_err && !lim && rcnt != 4'hf) begin
			rcnt <= rcnt + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < N; i++) begin
				st[i] <= cts_pkg::CTS_S_EMPTY;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (boff_ev && fob && (st[i] == cts_pkg::CTS_S_READY ||
					st[i] == cts_pkg::CTS_S_TXING ||
					st[i] == cts_pkg::CTS_S_ABTIP)) begin
					st[i] <= cts_pkg::CTS_S_FAILED;
				end else if (in_tx && SW'(i) == cur && ev_ok) begin
					st[i] <= cts_pkg::CTS_S_OK;
				end else if (in_tx && SW'(i) == cur && ev_err) begin
					if (lim) begin
						st[i] <= cts_pkg::CTS_S_FAILED;
					end else if (abort_now) begin
						st[i] <= cts_pkg::CTS_S_ABORTED;
					end else begin
						st[i] <= cts_pkg::CTS_S_READY;
					end
				end else if (start_ok && SW'(i) == pick) begin
					// An abort in the start cycle is kept, not lost.
					st[i] <= (cmd_sel[i] && w_q[`CTS_CMD_ABORT]) ?
						cts_pkg::CTS_S_ABTIP : cts_pkg::CTS_S_TXING;
				end else if (cmd_sel[i] && w_q[`CTS_CMD_ABORT]) begin
					if (st[i] == cts_pkg::CTS_S_READY) begin
						st[i] <= cts_pkg::CTS_S_ABORTED;
					end else if (st[i] == cts_pkg::CTS_S_TXING) begin
						st[i] <= cts_pkg::CTS_S_ABTIP;
					end
				end else if (cmd_sel[i] && w_q[`CTS_CMD_READY] &&
					open_slot(st[i])) begin
					st[i] <= (bus_off_i && fob) ?
						cts_pkg::CTS_S_ABORTED : cts_pkg::CTS_S_READY;
				end else if (cmd_sel[i] && w_q[`CTS_CMD_EMPTY] &&
					open_slot(st[i]) && st[i] != cts_pkg::CTS_S_EMPTY) begin
					st[i] <= cts_pkg::CTS_S_EMPTY;
				end
			end
		end
	end

	// Overload frames only ever echo a condition seen on the bus.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			overload_o <= 1'b0;
		end else begin
			overload_o <= overload_cond_i;
		end
	end

	// Classical frames never carry more than 8 payload bytes.
	wire drop = !tx_fd_o && tx_rd_word_i > `CTS_W_CLASSIC_LAST;
	cts_slot_mem #(.N(N), .WORDS(`CTS_WORDS)) u_mem (
		.sys_clk_i(sys_clk_i),
		.we_i(w_mem),
		.w_slot_i(w_slot),
		.w_word_i(w_word),
		.w_data_i(w_q),
		.w_strb_i(s_q),
		.r_slot_i(cur),
		.r_word_i(tx_rd_word_i),
		.r_zero_i(drop),
		.r_data_o(tx_word_o)
	);

	////////////////////////////////////////////////////////////////////////
	property p_tt_time;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		tx_start_o && $past(ttm) |->
			$past(time_base_i) >= {tsh[tx_slot_o], tsl[tx_slot_o]};
	endproperty
	a_tt_time: assert property (p_tt_time) else $error("early tt start");

	property p_idle;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		tx_start_o |-> $past(bus_idle_i) && !$past(rx_sof_i);
	endproperty
	a_idle: assert property (p_idle) else $error("start without idle");

	property p_fd;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		tx_start_o && !fde |-> !tx_fd_o;
	endproperty
	a_fd: assert property (p_fd) else $error("fd sent while disabled");

	property p_rtr;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		tx_start_o && fmt[tx_slot_o][`CTS_FMT_FDF] |-> !tx_rtr_o;
	endproperty
	a_rtr: assert property (p_rtr) else $error("remote fd frame");

	property p_fail;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		in_tx && tx_err_i && !boff_ev && rle && rcnt == rth |=>
			st[$past(cur)] == cts_pkg::CTS_S_FAILED;
	endproperty
	a_fail: assert property (p_fail) else $error("limit not failed");

	property p_cnt;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ev_err && !lim && !cur_abort && !(boff_ev && fob) &&
			rcnt != 4'hf |=> rcnt == $past(rcnt) + 4'h1;
	endproperty
	a_cnt: assert property (p_cnt) else $error("retry count slip");

	property p_boff;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		boff_ev && fob |=> rdy_vec == '0 && !in_tx;
	endproperty
	a_boff: assert property (p_boff) else $error("bus-off kept slot");

	property p_ovl;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		overload_o |-> $past(overload_cond_i);
	endproperty
	a_ovl: assert property (p_ovl) else $error("own overload");
endmodule // cts_tx_sched
`default_nettype wire

// File: test/cts_engine_model.sv
// Stand-in for the protocol engine and the other nodes on the bus.
`timescale 1ns/10ps
`default_nettype none
module cts_engine_model (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Behaviour chosen by the bench.
	input wire logic fail_i,
	input wire logic [7:0] dly_i,
	// Scheduler side.
	input wire logic tx_start_i,
	output logic bus_idle_o,
	output logic tx_ok_o,
	output logic tx_err_o
);
	int cnt;
	////////////////////////////////////////////////////////////////////
	// Each started frame ends after dly_i cycles in one outcome pulse.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 0;
			tx_ok_o <= 1'b0;
			tx_err_o <= 1'b0;
		end else begin
			tx_ok_o <= 1'b0;
			tx_err_o <= 1'b0;
			if (tx_start_i) begin
				cnt <= int'(dly_i);
			end else if (cnt == 1) begin
				tx_ok_o <= !fail_i;
				tx_err_o <= fail_i;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
	// The outcome cycle stands for the intermission, so the bus is not idle.
	assign bus_idle_o = (cnt == 0) && !tx_ok_o && !tx_err_o;
endmodule // cts_engine_model
`default_nettype wire

// File: test/cts_tx_sched_tb.sv
// Self-checking bench of the transmit slot scheduler.
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
module cts_tx_sched_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ovl_in = 1'b0, ovl_q = 1'b0;
	logic bus_off = 1'b0, fail = 1'b0, up = 1'b0, rx_sof = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, bus_idle, tx_ok, tx_err;
	logic tx_start, tx_fd, tx_rtr, ovl;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, tx_word, d;
	logic [31:0] dat [8];
	logic [1:0] bresp, rresp, rsp, tx_slot;
	logic [3:0] tx_dlc;
	logic [4:0] rd_word = 5'h00;
	logic [7:0] dly = 8'h04;
	logic [15:0] lf = 16'h0003;
	logic [63:0] tbase = 64'h0, tt;
	int error_cnt = 0, compares = 0, n_start = 0, m;
	int exp_st [4] = '{1, 1, 1, 1};
	int q [$];
	logic [63:0] ts [$];

	cts_tx_sched uut (.sys_clk_i(clk), .rst_b_i(rst_b),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .time_base_i(tbase),
		.bus_idle_i(bus_idle), .rx_sof_i(rx_sof), .tx_ok_i(tx_ok),
		.tx_err_i(tx_err), .bus_off_i(bus_off), .overload_cond_i(ovl_in),
		.tx_start_o(tx_start), .tx_slot_o(tx_slot), .tx_fd_o(tx_fd),
		.tx_rtr_o(tx_rtr), .tx_dlc_o(tx_dlc), .tx_rd_word_i(rd_word),
		.tx_word_o(tx_word), .overload_o(ovl));
	cts_engine_model peer (.sys_clk_i(clk), .rst_b_i(rst_b), .fail_i(fail),
		.dly_i(dly), .tx_start_i(tx_start), .bus_idle_o(bus_idle),
		.tx_ok_o(tx_ok), .tx_err_o(tx_err));

	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Bus tasks start and end just after an edge, so no signal is set twice.
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= v;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rsp = bresp;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		rsp = rresp;
		@(posedge clk);
	endtask
	task automatic cmd(input int k, input int c);
		wr(`CTS_OFF_COMMAND, (32'(k) << 8) | (32'h1 << c));
	endtask
	task automatic st_chk();
		rd(`CTS_OFF_STATUS);
		chk(d, {8'(exp_st[3]), 8'(exp_st[2]), 8'(exp_st[1]), 8'(exp_st[0])});
	endtask
	task automatic drain();
		while (q.size() != 0) @(posedge clk);
		repeat (int'(dly) + 4) @(posedge clk);
	endtask
	task automatic fill(input int k, input logic [31:0] f, input logic [31:0] t);
		for (int w = 0; w < 8; w++) begin
			dat[w] = (w == 0) ? f : (w == 2) ? t : (w == 3) ? 32'h0 : {lf, ~lf};
			wr(12'(256 * (k + 1) + 4 * w), dat[w]);
		end
	endtask
	task automatic look(input logic fd, input logic [31:0] w6);
		while (q.size() != 0) @(posedge clk);
		chk({tx_fd, tx_rtr, tx_dlc}, {fd, 1'b0, dat[0][3:0]});
		rd_word <= 5'h06;
		repeat (2) @(posedge clk);
		chk(tx_word, w6);
		rd_word <= 5'h04;
		repeat (2) @(posedge clk);
		chk(tx_word, dat[4]);
		drain();
		exp_st[0] = 16;
		st_chk();
	endtask

	////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;
	// Reference: expected start order in q, overload as a one-cycle echo.
	always @(posedge clk) begin
		tbase <= tbase + 64'h1;
		lf <= nxt(lf);
		ovl_in <= lf[0];
		ovl_q <= ovl_in;
		up <= rst_b;
		if (up) chk(ovl, ovl_q);
		if (tx_start === 1'b1) begin
			n_start++;
			ts.push_back(tbase);
			if (q.size() == 0) chk(64'h1, 64'h0);
			else chk(tx_slot, 64'(q.pop_front()));
		end
	end
	initial begin
		#(30000 * 100);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`CTS_OFF_SETTINGS);
		chk(d, `CTS_SET_RST);
		st_chk();
		rd(`CTS_OFF_COMMAND);
		chk(d, 32'h0);
		rd(12'h0fc);
		chk(rsp, `CTS_RESP_SLVERR);
		wr(`CTS_OFF_SETTINGS, 32'h65);
		fill(0, 32'haf, 32'h0);
		q = '{0};
		cmd(1, `CTS_CMD_READY);
		look(1'b0, 32'h0);
		wr(`CTS_OFF_MODE, 32'h2);
		q = '{0};
		cmd(1, `CTS_CMD_READY);
		look(1'b1, dat[6]);
		dly <= 8'd40;
		fail <= 1'b1;
		m = n_start;
		q = '{0, 0, 0};
		cmd(1, `CTS_CMD_READY);
		for (int k = 0; k < 3; k++) begin
			while (n_start < m + k + 1) @(posedge clk);
			rd(`CTS_OFF_RETRY);
			chk(d[3:0], k);
		end
		drain();
		exp_st[0] = 32;
		st_chk();
		wr(`CTS_OFF_SETTINGS, 32'h61);
		q = '{0};
		cmd(1, `CTS_CMD_READY);
		drain();
		st_chk();
		wr(`CTS_OFF_SETTINGS, 32'h60);
		m = n_start;
		q = '{0, 0, 0, 0, 0};
		cmd(1, `CTS_CMD_READY);
		while (n_start < m + 5) @(posedge clk);
		cmd(1, `CTS_CMD_ABORT);
		exp_st[0] = 8;
		st_chk();
		drain();
		exp_st[0] = 64;
		st_chk();
		wr(`CTS_OFF_SETTINGS, 32'h63);
		q = '{0, 0};
		cmd(1, `CTS_CMD_READY);
		drain();
		exp_st[0] = 32;
		st_chk();
		fail <= 1'b0;
		dly <= 8'h04;
		wr(`CTS_OFF_MODE, 32'h3);
		wr(`CTS_OFF_PRIORITY, 32'ha8);
		tt = tbase + 64'd400;
		fill(1, 32'h4, tt[31:0]);
		fill(2, 32'h4, 32'h0);
		ts = {};
		m = n_start;
		cmd(6, `CTS_CMD_READY);
		repeat (5) @(posedge clk);
		chk(n_start, m);
		q = '{2, 1};
		wr(`CTS_OFF_PRIORITY, 32'h88);
		drain();
		chk(ts[1], tt + 64'h1);
		exp_st[1] = 16;
		exp_st[2] = 16;
		st_chk();
		wr(`CTS_OFF_MODE, 32'h2);
		wr(`CTS_OFF_PRIORITY, 32'h0);
		fill(3, 32'h4, 32'h0);
		q = '{2, 3};
		cmd(12, `CTS_CMD_READY);
		drain();
		exp_st[3] = 16;
		st_chk();
		rx_sof <= 1'b1;
		m = n_start;
		cmd(8, `CTS_CMD_READY);
		repeat (5) @(posedge clk);
		chk(n_start, m);
		q = '{3};
		rx_sof <= 1'b0;
		drain();
		st_chk();
		wr(`CTS_OFF_MODE, 32'h3);
		wr(12'h208, 32'hffff_fff0);
		cmd(2, `CTS_CMD_READY);
		cmd(2, `CTS_CMD_ABORT);
		exp_st[1] = 64;
		st_chk();
		cmd(2, `CTS_CMD_READY);
		bus_off <= 1'b1;
		repeat (2) @(posedge clk);
		exp_st[1] = 32;
		st_chk();
		cmd(4, `CTS_CMD_READY);
		exp_st[2] = 64;
		st_chk();
		bus_off <= 1'b0;
		wr(`CTS_OFF_SETTINGS, 32'h40);
		dly <= 8'd40;
		m = n_start;
		q = '{3, 3};
		cmd(8, `CTS_CMD_READY);
		while (n_start == m) @(posedge clk);
		bus_off <= 1'b1;
		repeat (2) @(posedge clk);
		exp_st[3] = 2;
		st_chk();
		bus_off <= 1'b0;
		drain();
		exp_st[3] = 16;
		st_chk();
		tally_and_finish();
	end
endmodule // cts_tx_sched_tb
`default_nettype wire
